/* core/ioie_alu.sv */
// arithmetic unit: increment of a file value or or of literal into accumulator
// assumes purely combinational use from the executor
`timescale 1ns/1ns
module ioie_alu
   import ioie_pkg::*;
(
   ioie_alu_if.alu bus
);

   always_comb begin
      if (bus.op == or_literal_accumulator_op) begin
         bus.result = bus.accIn | bus.literal;
      end else begin
         bus.result = bus.operand + DATA_ONE;
      end
      bus.isZero = (bus.result == DATA_ZERO);
   end

endmodule : ioie_alu

/* core/ioie_alu_if.sv */
// carrier between the executor and its arithmetic unit
// assumes ioie_pkg is compiled first
`timescale 1ns/1ns
interface ioie_alu_if;
   import ioie_pkg::*;
   ioie_op_t op;
   logic [DATA_W-1:0] operand;
   logic [DATA_W-1:0] accIn;
   logic [DATA_W-1:0] literal;
   logic [DATA_W-1:0] result;
   logic isZero;

   modport core (output op, output operand, output accIn, output literal,
      input result, input isZero);
   modport alu (input op, input operand, input accIn, input literal,
      output result, output isZero);
endinterface : ioie_alu_if

/* core/ioie_exec.sv */
// executor for increment, increment-skip-if-zero and or-literal instructions
// assumes a register file with combinational read and a write taken one
// cycle after execution; the fetch stage holds the following word while
// squashActive is high.
//
// Behaviour
// - Increment register; result to accumulator when dest 0, else register; updates zero.
// - Increment-skip stores result by dest bit; leaves zero flag untouched.
// - Zero result of increment-skip discards the fetched next instruction as no-op.
// - Increment-skip one cycle, two when skipping; plain increment always one.
// - Or literal into accumulator, result to accumulator, update zero, one cycle.
`timescale 1ns/1ns
module ioie_exec
   import ioie_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic instrValid,
   input wire logic [INSTR_W-1:0] instrWord,
   output logic instrTaken,
   output logic squashActive,
   output logic [FADDR_W-1:0] regRdAddr,
   input wire logic [DATA_W-1:0] regRdData,
   output logic regWrEn,
   output logic [FADDR_W-1:0] regWrAddr,
   output logic [DATA_W-1:0] regWrData,
   output logic [DATA_W-1:0] accValue,
   output logic zeroFlag
);

   ioie_state_t state_reg;
   ioie_state_t state_next;
   logic [DATA_W-1:0] acc_reg;
   logic [DATA_W-1:0] acc_next;
   logic zero_reg;
   logic zero_next;
   logic wrEn_reg;
   logic wrEn_next;
   logic [FADDR_W-1:0] wrAddr_reg;
   logic [FADDR_W-1:0] wrAddr_next;
   logic [DATA_W-1:0] wrData_reg;
   logic [DATA_W-1:0] wrData_next;

   ioie_op_t curOp;
   logic destIsReg;
   logic [DATA_W-1:0] fileValue;

   ioie_alu_if aluBus();

   ioie_alu u_alu (
      .bus(aluBus)
   );

   assign curOp = ioie_decode(instrWord);
   assign destIsReg = (instrWord[DEST_BIT] != DEST_ACC);
   assign regRdAddr = instrWord[FADDR_MSB:0];

   // the register file writes one edge late, so a pending write is forwarded
   // to keep back-to-back increments of one register correct
   assign fileValue = (wrEn_reg && wrAddr_reg == regRdAddr) ? wrData_reg : regRdData;

   assign aluBus.op = curOp;
   assign aluBus.operand = fileValue;
   assign aluBus.accIn = acc_reg;
   assign aluBus.literal = instrWord[LIT_MSB:0];

   // the second cycle of a taken skip accepts nothing
   assign instrTaken = ce && instrValid && (state_reg == IOIE_ST_EXEC);
   assign squashActive = (state_reg == IOIE_ST_SQUASH);

   always_comb begin
      state_next = state_reg;
      acc_next = acc_reg;
      zero_next = zero_reg;
      wrEn_next = 1'h0;
      wrAddr_next = wrAddr_reg;
      wrData_next = wrData_reg;
      case (state_reg)
         IOIE_ST_EXEC: begin
            if (instrValid) begin
               case (curOp)
                  increment_register_op: begin
                     if (destIsReg) begin
                        wrEn_next = 1'h1;
                        wrAddr_next = regRdAddr;
                        wrData_next = aluBus.result;
                     end else begin
                        acc_next = aluBus.result;
                     end
                     zero_next = aluBus.isZero;
                  end
                  increment_skip_zero_op: begin
                     if (destIsReg) begin
                        wrEn_next = 1'h1;
                        wrAddr_next = regRdAddr;
                        wrData_next = aluBus.result;
                     end else begin
                        acc_next = aluBus.result;
                     end
                     if (aluBus.isZero) begin
                        state_next = IOIE_ST_SQUASH;
                     end
                  end
                  or_literal_accumulator_op: begin
                     acc_next = aluBus.result;
                     zero_next = aluBus.isZero;
                  end
                  default: begin
                     // other instructions belong to other units
                  end
               endcase
            end
         end
         IOIE_ST_SQUASH: begin
            state_next = IOIE_ST_EXEC;
         end
         default: begin
            state_next = IOIE_ST_EXEC;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_reg <= IOIE_ST_EXEC;
         acc_reg <= ACC_RESET;
         zero_reg <= ZERO_RESET;
         wrEn_reg <= 1'h0;
         wrAddr_reg <= '0;
         wrData_reg <= DATA_ZERO;
      end else if (ce) begin
         state_reg <= state_next;
         acc_reg <= acc_next;
         zero_reg <= zero_next;
         wrEn_reg <= wrEn_next;
         wrAddr_reg <= wrAddr_next;
         wrData_reg <= wrData_next;
      end
   end

   assign regWrEn = wrEn_reg;
   assign regWrAddr = wrAddr_reg;
   assign regWrData = wrData_reg;
   assign accValue = acc_reg;
   assign zeroFlag = zero_reg;

endmodule : ioie_exec

/* core/ioie_pkg.sv */
// constants, types and decode for the increment / or-literal executor
// assumes 12-bit instruction words and 8-bit data
package ioie_pkg;

   localparam int INSTR_W = 12;
   localparam int DATA_W = 8;
   localparam int FADDR_W = 5;

   // field positions inside the instruction word
   localparam int OPC6_MSB = 11;
   localparam int OPC6_LSB = 6;
   localparam int OPC4_MSB = 11;
   localparam int OPC4_LSB = 8;
   localparam int DEST_BIT = 5;
   localparam int FADDR_MSB = 4;
   localparam int LIT_MSB = 7;

   // opcode patterns
   localparam logic [5:0] INC_REG_PAT = 6'h0A;
   localparam logic [5:0] INC_SKIP_PAT = 6'h0F;
   localparam logic [3:0] OR_LIT_PAT = 4'hD;

   // values used by the datapath
   localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
   localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
   localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
   localparam logic ZERO_RESET = 1'h0;
   localparam logic DEST_ACC = 1'h0;

   typedef enum logic [1:0] {
      IOIE_OP_NONE,
      increment_register_op,
      increment_skip_zero_op,
      or_literal_accumulator_op
   } ioie_op_t;

   typedef enum logic {
      IOIE_ST_EXEC,
      IOIE_ST_SQUASH
   } ioie_state_t;

   function automatic ioie_op_t ioie_decode(input logic [INSTR_W-1:0] word);
      ioie_op_t op;
      op = IOIE_OP_NONE;
      if (word[OPC6_MSB:OPC6_LSB] == INC_REG_PAT) begin
         op = increment_register_op;
      end else if (word[OPC6_MSB:OPC6_LSB] == INC_SKIP_PAT) begin
         op = increment_skip_zero_op;
      end else if (word[OPC4_MSB:OPC4_LSB] == OR_LIT_PAT) begin
         op = or_literal_accumulator_op;
      end
      return op;
   endfunction : ioie_decode

endpackage : ioie_pkg

/* test/ioie_exec_properties.sv */
// timing relations of the executor outputs to the taken word
// assumes it is bound onto ioie_exec
`timescale 1ns/1ns
module ioie_exec_properties
   import ioie_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic instrValid,
   input wire logic [INSTR_W-1:0] instrWord,
   input wire logic instrTaken,
   input wire logic squashActive,
   input wire logic [FADDR_W-1:0] regRdAddr,
   input wire logic [DATA_W-1:0] regRdData,
   input wire logic regWrEn,
   input wire logic [FADDR_W-1:0] regWrAddr,
   input wire logic [DATA_W-1:0] regWrData,
   input wire logic [DATA_W-1:0] accValue,
   input wire logic zeroFlag
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   logic [DATA_W-1:0] opnd, incRes, orRes;
   logic dst;
   // the pending write is not in the file yet, so the operand is forwarded
   assign opnd = (regWrEn && regWrAddr == regRdAddr) ? regWrData : regRdData;
   assign incRes = opnd + DATA_ONE;
   assign orRes = accValue | instrWord[LIT_MSB:0];
   assign dst = instrWord[DEST_BIT];
   sequence take6(logic [5:0] pat);
      instrTaken && instrWord[OPC6_MSB:OPC6_LSB] == pat;
   endsequence
   chk_inc_acc: assert property (take6(INC_REG_PAT) ##0 !dst |=>
      accValue == $past(incRes) && zeroFlag == (accValue == DATA_ZERO) && !regWrEn)
      else $error("increment to accumulator wrong");
   chk_inc_file: assert property (take6(INC_REG_PAT) ##0 dst |=> regWrEn &&
      regWrAddr == $past(regRdAddr) && regWrData == $past(incRes) &&
      zeroFlag == ($past(incRes) == DATA_ZERO)) else $error("increment to file wrong");
   chk_skip_store: assert property (take6(INC_SKIP_PAT) |=> $stable(zeroFlag) &&
      ($past(dst) ? regWrEn && regWrData == $past(incRes) : accValue == $past(incRes)))
      else $error("increment-skip store wrong");
   chk_skip_squash: assert property (take6(INC_SKIP_PAT) ##0 incRes == DATA_ZERO |=>
      squashActive && !instrTaken ##1 (squashActive != $past(ce)))
      else $error("skip squash wrong");
   chk_no_skip: assert property (take6(INC_SKIP_PAT) ##0 incRes != DATA_ZERO |=>
      !squashActive) else $error("squash without zero result");
   chk_or_lit: assert property (instrTaken && instrWord[OPC4_MSB:OPC4_LSB] == OR_LIT_PAT
      |=> accValue == $past(orRes) && zeroFlag == (accValue == DATA_ZERO) && !regWrEn)
      else $error("or literal wrong");
   chk_idle_hold: assert property (!instrTaken && ce |=> $stable(accValue) &&
      $stable(zeroFlag) && !squashActive && !regWrEn) else $error("idle cycle changed state");
   chk_freeze_all: assert property (!ce |=> $stable(accValue) && $stable(zeroFlag) &&
      $stable(squashActive)) else $error("state moved with enable low");
endmodule : ioie_exec_properties
bind ioie_exec ioie_exec_properties ioie_exec_properties_i (.clk(clk), .nrst(nrst), .ce(ce),
   .instrValid(instrValid), .instrWord(instrWord), .instrTaken(instrTaken),
   .squashActive(squashActive), .regRdAddr(regRdAddr), .regRdData(regRdData),
   .regWrEn(regWrEn), .regWrAddr(regWrAddr), .regWrData(regWrData), .accValue(accValue),
   .zeroFlag(zeroFlag));

/* test/ioie_exec_test.sv */
// random instruction stream against a reference of accumulator, flag and file
// assumes the register file model on the file ports
`timescale 1ns/1ns
module ioie_exec_test;
   import ioie_pkg::*;
   typedef struct packed {logic [7:0] acc; logic z; logic sq; logic wen; logic [7:0] wd;} ioie_note_t;
   logic clk = 1'h0, nrst = 1'h0, ce = 1'h0, instrValid = 1'h0, squashActive, regWrEn, zeroFlag;
   logic [11:0] instrWord = 12'h000;
   logic [4:0] regRdAddr, regWrAddr;
   logic [7:0] regRdData, regWrData, accValue;
   logic [7:0] fm [32];
   ioie_note_t m;
   ioie_note_t notes[$];
   int n_mismatch = 0, check_count = 0, seed = 32'hEDFDDBC9;
   ioie_exec ioie_exec_i (.clk(clk), .nrst(nrst), .ce(ce), .instrValid(instrValid),
      .instrWord(instrWord), .instrTaken(), .squashActive(squashActive), .regRdAddr(regRdAddr),
      .regRdData(regRdData), .regWrEn(regWrEn), .regWrAddr(regWrAddr), .regWrData(regWrData),
      .accValue(accValue), .zeroFlag(zeroFlag));
   ioie_regfile_model ioie_regfile_model_i (.clk(clk), .rdAddr(regRdAddr), .rdData(regRdData),
      .wrEn(regWrEn), .wrAddr(regWrAddr), .wrData(regWrData));
   initial begin
      forever #50 clk = ~clk;
   end
   task give_verdict;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : give_verdict
   initial begin
      #500000;
      n_mismatch++;
      give_verdict;
   end
   initial begin
      ioie_note_t e;
      forever begin
         @(negedge clk);
         if (notes.size() > 0) begin
            e = notes.pop_front();
            check_count++;
            if ({accValue, zeroFlag, squashActive, regWrEn} !== {e.acc, e.z, e.sq, e.wen} || (e.wen && regWrData !== e.wd)) begin
               n_mismatch++;
               $display("wrong value outputs expected %h seen %h", e,
                  {accValue, zeroFlag, squashActive, regWrEn, regWrData});
            end
         end
      end
   end
   initial begin
      logic [1:0] op;
      logic [4:0] f;
      logic [7:0] r;
      // odd registers start at the wrap value so skips come early
      for (int k = 0; k < 32; k++) begin
         fm[k] = k[0] ? 8'hFF : 8'($random(seed));
         ioie_regfile_model_i.mem[k] = fm[k];
      end
      m = '0;
      repeat (16) @(negedge clk);
      nrst = 1'h1;
      for (int k = 0; k < 2000; k++) begin
         @(negedge clk);
         ce = |3'($random(seed));
         instrValid = |3'($random(seed));
         op = 2'($random(seed));
         f = 5'($random(seed));
         instrWord = {4'h7, 8'($random(seed))};
         if (op == 2'h0) instrWord = {INC_REG_PAT, 1'($random(seed)), f};
         if (op == 2'h1) instrWord = {INC_SKIP_PAT, 1'($random(seed)), f};
         if (op == 2'h2) instrWord = {OR_LIT_PAT, 8'($random(seed))};
         @(posedge clk);
         if (ce) begin
            r = fm[f] + 8'h01;
            m.wen = 1'h0;
            if (instrValid && !m.sq && op < 2'h2) begin
               if (instrWord[5]) begin
                  fm[f] = r;
                  m.wen = 1'h1;
                  m.wd = r;
               end else m.acc = r;
               if (op == 2'h0) m.z = r == 8'h00;
            end
            if (instrValid && !m.sq && op == 2'h2) begin
               m.acc = m.acc | instrWord[7:0];
               m.z = m.acc == 8'h00;
            end
            m.sq = instrValid && !m.sq && op == 2'h1 && r == 8'h00;
         end
         notes.push_back(m);
      end
      repeat (2) @(negedge clk);
      give_verdict;
   end
endmodule : ioie_exec_test

/* test/ioie_regfile_model.sv */
// register file standing in for the core data memory
// assumes a write lands at the edge where wrEn is high; reads are combinational
`timescale 1ns/1ns
module ioie_regfile_model
   import ioie_pkg::*;
(
   input wire logic clk,
   input wire logic [FADDR_W-1:0] rdAddr,
   output logic [DATA_W-1:0] rdData,
   input wire logic wrEn,
   input wire logic [FADDR_W-1:0] wrAddr,
   input wire logic [DATA_W-1:0] wrData
);
   logic [DATA_W-1:0] mem [32];
   assign rdData = mem[rdAddr];
   always @(posedge clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
   end
endmodule : ioie_regfile_model
